/* bit_manipulation_unit_tb.sv */
// Purpose: Self-checking bench for the bit manipulation unit
// Assumes: One-cycle answer on both the op and the query port
// Notes: Corner table on every op code, then seeded random back-to-back ops
`timescale 1ns/1ps
module bit_manipulation_unit_tb;
  // ****************************************
  // Signals
  // ****************************************
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic op_valid = 1'b0;
  bmu_pkg::bmu_op_t op_code = bmu_pkg::BMU_OP_AND_NOT;
  logic [63:0] src_a = '0;
  logic [63:0] src_b = '0;
  logic [4:0] dst_gpr = '0;
  logic id_valid = 1'b0;
  logic [31:0] id_leaf = '0;
  logic [31:0] id_subleaf = '0;
  logic res_valid, res_hi_valid, flags_we, id_ready;
  logic [63:0] res_lo, res_hi;
  logic [4:0] res_gpr;
  logic [31:0] id_ebx, id_ecx;
  int fails = 0;
  int checks = 0;
  logic [63:0] cv [6] = '{64'h0, '1, 64'h8000_0000_0000_0000, 64'h1, 64'h40, 64'hf0f0_0000_0000_ff3f};

  initial forever #5 clk_sys = ~clk_sys;

  bmu_core dut_u (.clk_sys(clk_sys), .rst(rst), .op_valid(op_valid), .op_code(op_code), .src_a(src_a),
    .src_b(src_b), .dst_gpr(dst_gpr), .id_valid(id_valid), .id_leaf(id_leaf), .id_subleaf(id_subleaf),
    .res_valid(res_valid), .res_lo(res_lo), .res_hi(res_hi), .res_hi_valid(res_hi_valid), .res_gpr(res_gpr),
    .flags_we(flags_we), .id_ready(id_ready), .id_ebx(id_ebx), .id_ecx(id_ecx));
  bmu_gpr_model model_u (.clk_sys(clk_sys), .rst(rst), .res_valid(res_valid), .res_gpr(res_gpr),
    .res_lo(res_lo), .flags_we(flags_we));

  // ****************************************
  // Expectations
  // ****************************************
  function automatic logic [127:0] ref_op(bmu_pkg::bmu_op_t op, logic [63:0] a, logic [63:0] b);
    logic [63:0] r;
    int k;
    int s;
    r = '0;
    k = 0;
    s = int'(b[5:0]);
    case (op)
      bmu_pkg::BMU_OP_AND_NOT: r = a & ~b;
      bmu_pkg::BMU_OP_ISOLATE, bmu_pkg::BMU_OP_MASK_UP, bmu_pkg::BMU_OP_CLEAR_LOW: begin
        // Walk up to the lowest one; a zero source never finds it
        r = (op == bmu_pkg::BMU_OP_CLEAR_LOW) ? a : 64'h0;
        for (int i = 0; i < 64; i++) if (k == 0) begin
          if (op == bmu_pkg::BMU_OP_MASK_UP) r[i] = 1'b1;
          if (a[i]) begin
            k = 1;
            r[i] = (op != bmu_pkg::BMU_OP_CLEAR_LOW);
          end
        end
      end
      bmu_pkg::BMU_OP_ZERO_HIGH: r = (b[7:0] >= 8'h40) ? a : a & ((64'h1 << b[7:0]) - 64'h1);
      bmu_pkg::BMU_OP_CLZ: begin
        r = 64'h40;
        for (int i = 0; i < 64; i++) if (a[i]) r = 64'(63 - i);
      end
      bmu_pkg::BMU_OP_CTZ: begin
        r = 64'h40;
        for (int i = 63; i >= 0; i--) if (a[i]) r = 64'(i);
      end
      bmu_pkg::BMU_OP_MUL: return {64'h0, a} * {64'h0, b};
      bmu_pkg::BMU_OP_SCATTER: for (int i = 0; i < 64; i++) if (b[i]) begin
        r[i] = a[k];
        k++;
      end
      bmu_pkg::BMU_OP_GATHER: for (int i = 0; i < 64; i++) if (b[i]) begin
        r[k] = a[i];
        k++;
      end
      bmu_pkg::BMU_OP_ROR: r = (a >> s) | (a << (64 - s));
      bmu_pkg::BMU_OP_BSWAP: for (int i = 0; i < 8; i++) r[8*i+:8] = a[56-8*i+:8];
      bmu_pkg::BMU_OP_EXTRACT: if (b[7:0] < 8'h40) begin
        r = a >> b[7:0];
        if (b[15:8] < 8'h40) r = r & ((64'h1 << b[15:8]) - 64'h1);
      end
      bmu_pkg::BMU_OP_SAR: r = $signed(a) >>> s;
      bmu_pkg::BMU_OP_SHL: r = a << s;
      default: r = a >> s;
    endcase
    return {64'h0, r};
  endfunction : ref_op

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(string what, logic [127:0] exp, logic [127:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask : step

  // Holds op_valid up between calls, so back-to-back ops need no gap
  task automatic issue(bmu_pkg::bmu_op_t op, logic [63:0] a, logic [63:0] b, logic [4:0] g, bit last);
    logic [127:0] e;
    e = ref_op(op, a, b);
    op_valid = 1'b1;
    op_code = op;
    src_a = a;
    src_b = b;
    dst_gpr = g;
    step();
    if (last) op_valid = 1'b0;
    chk("res_valid", 1, res_valid);
    chk($sformatf("res_lo op %0d", op), e[63:0], res_lo);
    chk("res_hi", e[127:64], res_hi);
    chk("res_hi_valid", op == bmu_pkg::BMU_OP_MUL, res_hi_valid);
    chk("res_gpr", g, res_gpr);
    chk("flags_we", 0, flags_we);
  endtask : issue

  // Holds id_valid up between calls, like issue
  task automatic ask(logic [31:0] leaf, logic [31:0] sub, logic [31:0] ebx, logic [31:0] ecx, bit last);
    id_valid = 1'b1;
    id_leaf = leaf;
    id_subleaf = sub;
    step();
    if (last) id_valid = 1'b0;
    chk("id_ready", 1, id_ready);
    chk($sformatf("id_ebx leaf %h", leaf), ebx, id_ebx);
    chk($sformatf("id_ecx leaf %h", leaf), ecx, id_ecx);
  endtask : ask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    #200000;
    fails++;
    wrap_up();
  end

  initial begin
    void'($urandom(32'hd2d425f8));
    repeat (6) @(posedge clk_sys);
    #1 rst = 1'b0;
    for (int o = 0; o < 16; o++) begin
      for (int i = 0; i < 6; i++) begin
        for (int j = 0; j < 6; j++) begin
          issue(bmu_pkg::bmu_op_t'(o[3:0]), cv[i], cv[j], 5'(i * 6 + j), (i == 5) && (j == 5));
        end
      end
      step();
      chk("res_valid idle", 0, res_valid);
      chk("res_lo idle", 0, res_lo);
      chk("gpr write-back", ref_op(bmu_pkg::bmu_op_t'(o[3:0]), cv[5], cv[5]) & 128'h0000_0000_0000_0000_ffff_ffff_ffff_ffff,
        {64'h0, model_u.gpr_q[35 % 32]});
    end
    $display("test corner table done");
    for (int n = 0; n < 400; n++) begin
      logic [63:0] b;
      b = {$urandom, $urandom};
      if (n % 2 == 0) b[15:0] = {8'($urandom_range(70)), 8'($urandom_range(70))};
      issue(bmu_pkg::bmu_op_t'(4'($urandom_range(15))), {$urandom, $urandom}, b, 5'($urandom), n == 399);
    end
    $display("test random ops done");
    ask(bmu_pkg::LEAF_EXT_FEAT, bmu_pkg::SUBLEAF_ZERO, (32'h1 << bmu_pkg::BIT_GROUP_ONE) | (32'h1 << bmu_pkg::BIT_GROUP_TWO),
      32'h1 << bmu_pkg::BIT_PREFW_T1, 0);
    ask(bmu_pkg::LEAF_EXT_INFO, 0, 0,
      (32'h1 << bmu_pkg::BIT_LEAD_COUNT) | (32'h1 << bmu_pkg::BIT_PREFW), 0);
    ask(bmu_pkg::LEAF_BASIC, 0, 0, 32'h1 << bmu_pkg::BIT_BSWAP_MOVE, 0);
    ask(bmu_pkg::LEAF_EXT_FEAT, 32'h1, 0, 0, 0);
    ask(32'h2, 0, 0, 0, 1);
    step();
    chk("id_ready idle", 0, id_ready);
    chk("id_ebx idle", 0, id_ebx);
    $display("test identification done");
    chk("flag writes before reset", 0, model_u.flag_writes_q);
    op_valid = 1'b1;
    rst = 1'b1;
    step();
    chk("res_valid in reset", 0, res_valid);
    rst = 1'b0;
    issue(bmu_pkg::BMU_OP_BSWAP, 64'h0102_0304_0506_0708, 0, 5'h1f, 1);
    chk("flag writes", 0, model_u.flag_writes_q);
    $display("test reset recovery done");
    wrap_up();
  end
endmodule : bit_manipulation_unit_tb

/* bmu_core.sv */
// Purpose: General-purpose-register bit manipulation datapath
// Assumes: Operands come from the register file with op_valid
// Notes: One-cycle latency, results registered, flags never driven
//
// What this block does
// - And-not gives first source AND complement of second source
// - Isolate keeps only the lowest set bit of the source
// - Mask sets every bit up to and including the lowest set bit to one
// - Clear-lowest clears the lowest set bit, others unchanged
// - Zero-high clears bits from index upward, lower bits pass
// - Leading count counts zeros from the most significant bit
// - Trailing count counts zeros from the least significant bit
// - Flagless multiply gives unsigned product and leaves flags unchanged
// - Scatter places low source bits at mask-selected positions, rest zero
// - Gather packs mask-selected source bits into low result bits
// - Flagless rotate turns source right by count, flags unchanged
// - Byte-swapping move reverses byte order of the moved word
// - Operations use general registers only, never vector registers
// - Leaf 07H subleaf 0 EBX bit 3 reports group one
// - Leaf 07H subleaf 0 EBX bit 8 reports group two
// - Leaf 80000001H ECX bit 5 reports leading count
// - Write-intent prefetch bits: 80000001H ECX 8, 07H ECX 0
// - Leaf 01 ECX bit 22 reports the byte-swapping move
`timescale 1ns/1ps
module bmu_core (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic op_valid,
  input wire bmu_pkg::bmu_op_t op_code,
  input wire logic [bmu_pkg::XLEN-1:0] src_a,
  input wire logic [bmu_pkg::XLEN-1:0] src_b,
  input wire logic [4:0] dst_gpr,
  input wire logic id_valid,
  input wire logic [31:0] id_leaf,
  input wire logic [31:0] id_subleaf,
  output logic res_valid,
  output logic [bmu_pkg::XLEN-1:0] res_lo,
  output logic [bmu_pkg::XLEN-1:0] res_hi,
  output logic res_hi_valid,
  output logic [4:0] res_gpr,
  output logic flags_we,
  output logic id_ready,
  output logic [31:0] id_ebx,
  output logic [31:0] id_ecx
);
  localparam int unsigned W = bmu_pkg::XLEN;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [bmu_pkg::CNTW-1:0] lead_zeros(input logic [W-1:0] v);
    logic [bmu_pkg::CNTW-1:0] n;
    logic seen;
    n = '0;
    seen = 1'b0;
    for (int i = W - 1; i >= 0; i--) begin
      if (v[i]) begin
        seen = 1'b1;
      end
      if (!seen) begin
        n = n + 1'b1;
      end
    end
    return n;
  endfunction : lead_zeros

  function automatic logic [W-1:0] bit_reverse(input logic [W-1:0] v);
    logic [W-1:0] r;
    r = '0;
    for (int i = 0; i < W; i++) begin
      r[i] = v[W-1-i];
    end
    return r;
  endfunction : bit_reverse

  function automatic logic [W-1:0] low_mask(input logic [bmu_pkg::IDXW-1:0] n);
    logic [W-1:0] m;
    m = '0;
    for (int i = 0; i < W; i++) begin
      m[i] = (i < int'(n));
    end
    return m;
  endfunction : low_mask

  function automatic logic [W-1:0] lowest_one(input logic [W-1:0] v);
    return v & (~v + 1'b1);
  endfunction : lowest_one

  // ****************************************
  // Datapath
  // ****************************************
  logic [W-1:0] lo_d;
  logic [W-1:0] lo_q;
  logic [W-1:0] hi_d;
  logic [W-1:0] hi_q;
  logic hiv_d;
  logic hiv_q;
  logic vld_d;
  logic vld_q;
  logic [4:0] gpr_d;
  logic [4:0] gpr_q;
  logic [2*W-1:0] prod;
  logic [bmu_pkg::IDXW-1:0] idx;
  logic [bmu_pkg::IDXW-1:0] flen;
  logic [bmu_pkg::SHW-1:0] sh;
  logic [W-1:0] fshift;
  int unsigned k;

  // Full-width product in one cycle; timing traded for latency
  assign prod = src_a * src_b;
  assign idx = src_b[bmu_pkg::IDXW-1:0];
  assign flen = src_b[2*bmu_pkg::IDXW-1:bmu_pkg::IDXW];
  assign sh = src_b[bmu_pkg::SHW-1:0];
  assign fshift = (idx >= bmu_pkg::IDXW'(W)) ? '0 : (src_a >> idx);

  always_comb begin
    lo_d = '0;
    hi_d = '0;
    hiv_d = 1'b0;
    k = 0;
    vld_d = op_valid;
    gpr_d = op_valid ? dst_gpr : gpr_q;
    if (op_valid) begin
      case (op_code)
        bmu_pkg::BMU_OP_AND_NOT: lo_d = src_a & ~src_b;
        bmu_pkg::BMU_OP_ISOLATE: lo_d = lowest_one(src_a);
        bmu_pkg::BMU_OP_MASK_UP: lo_d = src_a ^ (src_a - 1'b1);
        bmu_pkg::BMU_OP_CLEAR_LOW: lo_d = src_a & (src_a - 1'b1);
        bmu_pkg::BMU_OP_ZERO_HIGH: lo_d = (idx >= bmu_pkg::IDXW'(W)) ? src_a : (src_a & low_mask(idx));
        bmu_pkg::BMU_OP_CLZ: lo_d = W'(lead_zeros(src_a));
        bmu_pkg::BMU_OP_CTZ: lo_d = W'(lead_zeros(bit_reverse(src_a)));
        bmu_pkg::BMU_OP_MUL: begin
          lo_d = prod[W-1:0];
          hi_d = prod[2*W-1:W];
          hiv_d = 1'b1;
        end
        bmu_pkg::BMU_OP_SCATTER: begin
          for (int i = 0; i < W; i++) begin
            if (src_b[i]) begin
              lo_d[i] = src_a[k];
              k = k + 1;
            end
          end
        end
        bmu_pkg::BMU_OP_GATHER: begin
          for (int i = 0; i < W; i++) begin
            if (src_b[i]) begin
              lo_d[k] = src_a[i];
              k = k + 1;
            end
          end
        end
        bmu_pkg::BMU_OP_ROR: lo_d = (src_a >> sh) | (src_a << (bmu_pkg::SHW'(W - 1) - sh + 1'b1));
        bmu_pkg::BMU_OP_BSWAP: begin
          for (int i = 0; i < W / 8; i++) begin
            lo_d[8*i +: 8] = src_a[W-8-8*i +: 8];
          end
        end
        bmu_pkg::BMU_OP_EXTRACT: lo_d = (flen >= bmu_pkg::IDXW'(W)) ? fshift : (fshift & low_mask(flen));
        bmu_pkg::BMU_OP_SAR: lo_d = W'($signed(src_a) >>> sh);
        bmu_pkg::BMU_OP_SHL: lo_d = src_a << sh;
        bmu_pkg::BMU_OP_SHR: lo_d = src_a >> sh;
        default: lo_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lo_q <= '0;
      hi_q <= '0;
      hiv_q <= 1'b0;
      vld_q <= 1'b0;
      gpr_q <= '0;
    end else begin
      lo_q <= lo_d;
      hi_q <= hi_d;
      hiv_q <= hiv_d;
      vld_q <= vld_d;
      gpr_q <= gpr_d;
    end
  end

  assign res_valid = vld_q;
  assign res_lo = lo_q;
  assign res_hi = hi_q;
  assign res_hi_valid = hiv_q;
  assign res_gpr = gpr_q;
  // No op here writes the status flags
  assign flags_we = 1'b0;

  // ****************************************
  // Identification
  // ****************************************
  bmu_id u_id (
    .clk_sys(clk_sys),
    .rst(rst),
    .id_valid(id_valid),
    .id_leaf(id_leaf),
    .id_subleaf(id_subleaf),
    .id_ready(id_ready),
    .id_ebx(id_ebx),
    .id_ecx(id_ecx)
  );

  // ****************************************
  // Checks
  // ****************************************
  a_and_not: assert property (@(posedge clk_sys) disable iff (rst)
    op_valid && op_code == bmu_pkg::BMU_OP_AND_NOT |=> res_valid && res_lo == ($past(src_a) & ~$past(src_b)))
    else $error("and-not result wrong");
  a_isolate_one: assert property (@(posedge clk_sys) disable iff (rst)
    op_valid && op_code == bmu_pkg::BMU_OP_ISOLATE |=> $onehot0(res_lo) && ((res_lo & $past(src_a)) == res_lo)
      && (($past(src_a) & (res_lo - 1'b1)) == '0))
    else $error("isolate result wrong");
  a_mask_up: assert property (@(posedge clk_sys) disable iff (rst)
    op_valid && op_code == bmu_pkg::BMU_OP_MASK_UP && src_a[0] |=> res_lo == W'(1))
    else $error("mask result wrong");
  a_mask_form: assert property (@(posedge clk_sys) disable iff (rst)
    op_valid && op_code == bmu_pkg::BMU_OP_MASK_UP |=> res_lo != '0 && (res_lo & (res_lo + 1'b1)) == '0)
    else $error("mask shape wrong");
  a_clear_low: assert property (@(posedge clk_sys) disable iff (rst)
    op_valid && op_code == bmu_pkg::BMU_OP_CLEAR_LOW |=> (res_lo ^ lowest_one($past(src_a))) == $past(src_a))
    else $error("clear-lowest result wrong");
  a_zero_high: assert property (@(posedge clk_sys) disable iff (rst)
    op_valid && op_code == bmu_pkg::BMU_OP_ZERO_HIGH && src_b[bmu_pkg::IDXW-1:0] == '0 |=> res_lo == '0)
    else $error("zero-high result wrong");
  a_zero_top: assert property (@(posedge clk_sys) disable iff (rst)
    op_valid && op_code == bmu_pkg::BMU_OP_ZERO_HIGH && idx < bmu_pkg::IDXW'(W) |=> (res_lo >> $past(idx)) == '0)
    else $error("zero-high left high bits");
  // Shift past the width empties the word, so large indexes check nothing here
  a_zero_keep: assert property (@(posedge clk_sys) disable iff (rst)
    op_valid && op_code == bmu_pkg::BMU_OP_ZERO_HIGH |=> ((res_lo ^ $past(src_a)) << (W - $past(idx))) == '0)
    else $error("zero-high changed low bits");
  a_lead_count: assert property (@(posedge clk_sys) disable iff (rst)
    op_valid && op_code == bmu_pkg::BMU_OP_CLZ && src_a == '0 |=> res_lo == W'(W))
    else $error("leading count wrong");
  a_lead_top: assert property (@(posedge clk_sys) disable iff (rst)
    op_valid && op_code == bmu_pkg::BMU_OP_CLZ && src_a[W-1] |=> res_lo == '0)
    else $error("leading count of top bit wrong");
  a_lead_exact: assert property (@(posedge clk_sys) disable iff (rst)
    op_valid && op_code == bmu_pkg::BMU_OP_CLZ && src_a != '0 |=> (($past(src_a) << res_lo) >> (W - 1)) == W'(1)
      && ($past(src_a) >> (W - res_lo)) == '0)
    else $error("leading count not at first one");
  a_trail_count: assert property (@(posedge clk_sys) disable iff (rst)
    op_valid && op_code == bmu_pkg::BMU_OP_CTZ && src_a[0] |=> res_lo == '0)
    else $error("trailing count wrong");
  a_trail_empty: assert property (@(posedge clk_sys) disable iff (rst)
    op_valid && op_code == bmu_pkg::BMU_OP_CTZ && src_a == '0 |=> res_lo == W'(W))
    else $error("trailing count of zero wrong");
  a_trail_exact: assert property (@(posedge clk_sys) disable iff (rst)
    op_valid && op_code == bmu_pkg::BMU_OP_CTZ && src_a != '0 |=> (($past(src_a) >> res_lo) & W'(1)) == W'(1)
      && ($past(src_a) << (W - res_lo)) == '0)
    else $error("trailing count not at first one");
  a_mul_flags: assert property (@(posedge clk_sys) disable iff (rst)
    op_valid && op_code == bmu_pkg::BMU_OP_MUL |=> res_hi_valid && !flags_we
      && {res_hi, res_lo} == $past(src_a) * $past(src_b))
    else $error("multiply wrong");
  a_hi_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    op_valid && op_code != bmu_pkg::BMU_OP_MUL |=> !res_hi_valid && res_hi == '0)
    else $error("high half outside multiply");
  a_scatter_mask: assert property (@(posedge clk_sys) disable iff (rst)
    op_valid && op_code == bmu_pkg::BMU_OP_SCATTER |=> (res_lo & ~$past(src_b)) == '0)
    else $error("scatter outside mask");
  a_scatter_all: assert property (@(posedge clk_sys) disable iff (rst)
    op_valid && op_code == bmu_pkg::BMU_OP_SCATTER && src_b == '1 |=> res_lo == $past(src_a))
    else $error("scatter full mask wrong");
  a_gather_all: assert property (@(posedge clk_sys) disable iff (rst)
    op_valid && op_code == bmu_pkg::BMU_OP_GATHER && src_b == '1 |=> res_lo == $past(src_a))
    else $error("gather result wrong");
  a_gather_none: assert property (@(posedge clk_sys) disable iff (rst)
    op_valid && op_code == bmu_pkg::BMU_OP_GATHER && src_b == '0 |=> res_lo == '0)
    else $error("gather empty mask wrong");
  a_rotate_right: assert property (@(posedge clk_sys) disable iff (rst)
    op_valid && op_code == bmu_pkg::BMU_OP_ROR |=> !flags_we
      && ((res_lo << $past(sh)) | (res_lo >> (W - $past(sh)))) == $past(src_a))
    else $error("rotate result wrong");
  a_byte_swap: assert property (@(posedge clk_sys) disable iff (rst)
    op_valid && op_code == bmu_pkg::BMU_OP_BSWAP |=> res_lo[7:0] == $past(src_a[W-1:W-8]))
    else $error("byte swap wrong");
  a_swap_top_byte: assert property (@(posedge clk_sys) disable iff (rst)
    op_valid && op_code == bmu_pkg::BMU_OP_BSWAP |=> res_lo[W-1:W-8] == $past(src_a[7:0]))
    else $error("byte swap top byte wrong");
  a_gpr_dest: assert property (@(posedge clk_sys) disable iff (rst)
    op_valid |=> res_gpr == $past(dst_gpr))
    else $error("destination register wrong");
  a_gpr_hold: assert property (@(posedge clk_sys) disable iff (rst)
    !op_valid |=> res_gpr == $past(res_gpr))
    else $error("destination register moved while idle");
  a_idle_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    !op_valid |=> !res_valid && !res_hi_valid && res_lo == '0 && res_hi == '0)
    else $error("result without operation");
  a_extract_zero: assert property (@(posedge clk_sys) disable iff (rst)
    op_valid && op_code == bmu_pkg::BMU_OP_EXTRACT && idx >= bmu_pkg::IDXW'(W) |=> res_lo == '0)
    else $error("extract past word not zero");
  a_extract_len: assert property (@(posedge clk_sys) disable iff (rst)
    op_valid && op_code == bmu_pkg::BMU_OP_EXTRACT && flen < bmu_pkg::IDXW'(W) |=> (res_lo >> $past(flen)) == '0)
    else $error("extract wider than length");
  a_shift_left: assert property (@(posedge clk_sys) disable iff (rst)
    op_valid && op_code == bmu_pkg::BMU_OP_SHL |=> res_lo == $past(src_a) * (W'(1) << $past(sh)))
    else $error("left shift wrong");
  a_shift_right: assert property (@(posedge clk_sys) disable iff (rst)
    op_valid && op_code == bmu_pkg::BMU_OP_SHR |=> (res_lo >> (W - $past(sh))) == '0
      && (res_lo << $past(sh)) == ($past(src_a) & ~((W'(1) << $past(sh)) - 1'b1)))
    else $error("right shift wrong");
  a_shift_sign: assert property (@(posedge clk_sys) disable iff (rst)
    op_valid && op_code == bmu_pkg::BMU_OP_SAR |=> res_lo[W-1] == $past(src_a[W-1])
      && (res_lo << $past(sh)) == ($past(src_a) & ~((W'(1) << $past(sh)) - 1'b1)))
    else $error("arithmetic shift wrong");
endmodule : bmu_core

/* bmu_gpr_model.sv */
// Purpose: Register file and flags model on the write-back side of the core
// Assumes: Results arrive with res_valid, one per cycle while it stays high for back-to-back ops
// Notes: Flags move only when flags_we is seen, so any flag write is counted
`timescale 1ns/1ps
module bmu_gpr_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic res_valid,
  input wire logic [4:0] res_gpr,
  input wire logic [bmu_pkg::XLEN-1:0] res_lo,
  input wire logic flags_we
);
  // ****************************************
  // State
  // ****************************************
  logic [bmu_pkg::XLEN-1:0] gpr_q [32];
  int unsigned flag_writes_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flag_writes_q <= 0;
    end else begin
      if (res_valid) begin
        gpr_q[res_gpr] <= res_lo;
      end
      // A flag write here would clobber the caller's status bits
      if (flags_we !== 1'b0) begin
        flag_writes_q <= flag_writes_q + 1;
      end
    end
  end
endmodule : bmu_gpr_model

/* bmu_id.sv */
// Purpose: Feature identification answer for the bit operations
// Assumes: Leaf and subleaf valid with query strobe
// Notes: Answers are registered, one cycle after the query
`timescale 1ns/1ps
module bmu_id (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic id_valid,
  input wire logic [31:0] id_leaf,
  input wire logic [31:0] id_subleaf,
  output logic id_ready,
  output logic [31:0] id_ebx,
  output logic [31:0] id_ecx
);
  logic [31:0] ebx_d;
  logic [31:0] ebx_q;
  logic [31:0] ecx_d;
  logic [31:0] ecx_q;
  logic rdy_d;
  logic rdy_q;

  // ****************************************
  // Leaf decode
  // ****************************************
  always_comb begin
    ebx_d = '0;
    ecx_d = '0;
    rdy_d = id_valid;
    if (id_valid) begin
      if (id_leaf == bmu_pkg::LEAF_EXT_FEAT && id_subleaf == bmu_pkg::SUBLEAF_ZERO) begin
        ebx_d[bmu_pkg::BIT_GROUP_ONE] = 1'b1;
        ebx_d[bmu_pkg::BIT_GROUP_TWO] = 1'b1;
        ecx_d[bmu_pkg::BIT_PREFW_T1] = 1'b1;
      end else if (id_leaf == bmu_pkg::LEAF_EXT_INFO) begin
        ecx_d[bmu_pkg::BIT_LEAD_COUNT] = 1'b1;
        ecx_d[bmu_pkg::BIT_PREFW] = 1'b1;
      end else if (id_leaf == bmu_pkg::LEAF_BASIC) begin
        ecx_d[bmu_pkg::BIT_BSWAP_MOVE] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ebx_q <= '0;
      ecx_q <= '0;
      rdy_q <= 1'b0;
    end else begin
      ebx_q <= ebx_d;
      ecx_q <= ecx_d;
      rdy_q <= rdy_d;
    end
  end

  assign id_ready = rdy_q;
  assign id_ebx = ebx_q;
  assign id_ecx = ecx_q;

  a_group_bits: assert property (@(posedge clk_sys) disable iff (rst)
    id_valid && id_leaf == bmu_pkg::LEAF_EXT_FEAT && id_subleaf == bmu_pkg::SUBLEAF_ZERO
    |=> id_ebx[bmu_pkg::BIT_GROUP_ONE] && id_ebx[bmu_pkg::BIT_GROUP_TWO])
    else $error("group bits missing");
  a_ext_bits: assert property (@(posedge clk_sys) disable iff (rst)
    id_valid && id_leaf == bmu_pkg::LEAF_EXT_INFO
    |=> id_ecx[bmu_pkg::BIT_LEAD_COUNT] && id_ecx[bmu_pkg::BIT_PREFW])
    else $error("extended leaf bits missing");
  a_basic_bit: assert property (@(posedge clk_sys) disable iff (rst)
    id_valid && id_leaf == bmu_pkg::LEAF_BASIC |=> id_ready && id_ecx[bmu_pkg::BIT_BSWAP_MOVE])
    else $error("byte swap move bit missing");
  a_t1_bit: assert property (@(posedge clk_sys) disable iff (rst)
    id_valid && id_leaf == bmu_pkg::LEAF_EXT_FEAT && id_subleaf == bmu_pkg::SUBLEAF_ZERO
    |=> id_ecx[bmu_pkg::BIT_PREFW_T1])
    else $error("t1 prefetch bit missing");
  a_id_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    !id_valid |=> !id_ready && id_ebx == '0 && id_ecx == '0)
    else $error("answer without query");
endmodule : bmu_id

/* bmu_pkg.sv */
// Purpose: Shared constants for the bit manipulation unit
// Assumes: 64-bit general-purpose operands
// Notes: Identification bit positions and op encodings
package bmu_pkg;
  // ****************************************
  // Widths
  // ****************************************
  localparam int unsigned XLEN = 64;
  localparam int unsigned CNTW = 7;
  localparam int unsigned IDXW = 8;
  localparam int unsigned SHW = 6;

  // ****************************************
  // Operations
  // ****************************************
  typedef enum logic [3:0] {
    BMU_OP_AND_NOT = 4'h0,
    BMU_OP_ISOLATE = 4'h1,
    BMU_OP_MASK_UP = 4'h2,
    BMU_OP_CLEAR_LOW = 4'h3,
    BMU_OP_ZERO_HIGH = 4'h4,
    BMU_OP_CLZ = 4'h5,
    BMU_OP_CTZ = 4'h6,
    BMU_OP_MUL = 4'h7,
    BMU_OP_SCATTER = 4'h8,
    BMU_OP_GATHER = 4'h9,
    BMU_OP_ROR = 4'ha,
    BMU_OP_BSWAP = 4'hb,
    BMU_OP_EXTRACT = 4'hc,
    BMU_OP_SAR = 4'hd,
    BMU_OP_SHL = 4'he,
    BMU_OP_SHR = 4'hf
  } bmu_op_t;

  // ****************************************
  // Identification query
  // ****************************************
  localparam logic [31:0] LEAF_BASIC = 32'h0000_0001;
  localparam logic [31:0] LEAF_EXT_FEAT = 32'h0000_0007;
  localparam logic [31:0] LEAF_EXT_INFO = 32'h8000_0001;
  localparam logic [31:0] SUBLEAF_ZERO = 32'h0000_0000;
  localparam int unsigned BIT_GROUP_ONE = 3;
  localparam int unsigned BIT_GROUP_TWO = 8;
  localparam int unsigned BIT_LEAD_COUNT = 5;
  localparam int unsigned BIT_PREFW = 8;
  localparam int unsigned BIT_PREFW_T1 = 0;
  localparam int unsigned BIT_BSWAP_MOVE = 22;
endpackage : bmu_pkg
